// ===== slcm_defs.svh
// Register offsets, field positions, reset values and timing counts of the line coder
`ifndef SLCM_DEFS_SVH
`define SLCM_DEFS_SVH
`define SLCM_OFF_CFG0 12'h000
`define SLCM_OFF_CFG1 12'h004
`define SLCM_OFF_CFG2 12'h008
`define SLCM_OFF_CFG3 12'h00c
`define SLCM_OFF_MODE 12'h010
`define SLCM_OFF_XBC 12'h014
`define SLCM_OFF_ISR 12'h018
`define SLCM_OFF_IMR 12'h01c
`define SLCM_OFF_TXC 12'h020
`define SLCM_OFF_STAT 12'h024
`define SLCM_CFG0_PU 7
`define SLCM_CFG0_BUS 4
`define SLCM_CFG0_CODE_LSB 2
`define SLCM_CFG1_CM_LSB 0
`define SLCM_CFG2_SOC_LSB 6
`define SLCM_CFG2_DIV 3
`define SLCM_MODE_RAC 3
`define SLCM_MODE_RTS 2
`define SLCM_MODE_TLP 0
`define SLCM_XBC_CAS 7
`define SLCM_ISR_CTSC 1
`define SLCM_ISR_XMR 4
`define SLCM_TXC_SEND 0
`define SLCM_TXC_ASYNC 1
`define SLCM_TXC_POOL 2
`define SLCM_RST8 8'h00
`define SLCM_IMR_RST 8'hff
`define SLCM_RST_TIME_US 5
`endif

// ===== slcm_modem.sv
// Behavioural modem standing on the far side of the serial line
`timescale 1ns/1ns
// ----------------
// Modem model
// ----------------
module slcm_modem (
	input wire logic run,
	input wire logic grant,
	input wire logic carrier,
	output logic line_clk,
	output logic cts_n,
	output logic cd,
	output logic rxd
);
	// Permission and carrier follow the bench's commands
	assign cts_n = !grant;
	assign cd = carrier;
	// Idle receive line rests at its pull-up level
	assign rxd = 1'b1;
	// Bit clock stands still while run is low; odd offset keeps it unrelated to pclk
	initial begin
		line_clk = 1'b0;
		#3;
		forever begin
			#16;
			line_clk = run ? ~line_clk : 1'b0;
		end
	end
endmodule

// ===== slcm_pkg.sv
// Types shared by the line coder
package slcm_pkg;
	typedef enum logic [2:0] {
		SLCM_NRZ = 3'h0,
		SLCM_NRZI = 3'h1,
		SLCM_FM0 = 3'h2,
		SLCM_FM1 = 3'h3,
		SLCM_MAN = 3'h4
	} slcm_code_t;
	typedef enum logic [1:0] {
		SLCM_IDLE = 2'h0,
		SLCM_REQ = 2'h1,
		SLCM_SEND = 2'h3,
		SLCM_DRAIN = 2'h2
	} slcm_tx_t;
	typedef struct packed {
		logic [7:0] cfg0;
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic [7:0] cfg3;
		logic [7:0] mode;
		logic [7:0] xbc;
		logic [7:0] isr;
		logic [7:0] imr;
		logic [2:0] txc;
		logic [1:0] cts_s;
		logic [1:0] cd_s;
		logic [1:0] rxd_s;
		logic [1:0] clk_s;
		logic clk_d;
		logic cts_d;
		slcm_tx_t tx;
		logic txd_lvl;
		logic tx_bit;
		logic [2:0] bitcnt;
		logic rx_en;
		logic rx_last;
		logic [2:0] rxcnt;
		logic rx_prev;
		logic rx_bit;
		logic rx_valid;
		logic rx_frame;
		logic rts_n;
		logic txd;
		logic txd_oe;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} slcm_state_t;
endpackage

// ===== slcm_top.sv
// Line coding, modem handshake and loopback logic of one serial channel
`timescale 1ns/1ns
`include "slcm_defs.svh"

// How it works
// - NRZ line level equals data bit
// - Inversion bit inverts transmit and receive data
// - NRZI zero toggles, one holds level
// - FM0 edge each cell, mid edge zero
// - FM1 edge each cell, mid edge one
// - Manchester data first half, inverted second
// - Transmit leads receive by quarter bit
// - RTS low on request, or software driven
// - Send only after CTS granted
// - Framed CTS loss aborts, resends if buffered
// - Framed CTS loss after pool release resets transmitter
// - Async CTS loss finishes current character
// - CTS change sets flag, masked interrupt
// - Select 11 drives RTS low during reception
// - Select 10 holds RTS high
// - CD high starts receiver except mode one
// - CD low finishes current byte first
// - Test loop connects transmit to receive
// - Config registers reset to zero, powered down
// - Reset gives auto RTS, receiver off
module slcm_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic line_clk,
	input wire logic cts_n,
	input wire logic cd,
	input wire logic rxd,
	input wire logic tx_data,
	output logic tx_take,
	output logic rx_data,
	output logic rx_valid,
	output logic tx_repeat,
	output logic cts_irq,
	output logic rts_n,
	output logic txd,
	output logic txd_oe
);
	slcm_pkg::slcm_state_t q;
	slcm_pkg::slcm_state_t next_q;
	logic take_q;
	logic next_take;

	// Line encoder: level for the given half cell; first marks cell start
	function automatic logic enc(input logic [2:0] code, input logic lvl, input logic b,
		input logic first);
		logic r;
		r = lvl;
		unique case (code)
			3'h1: r = first ? (b ? lvl : ~lvl) : lvl;
			3'h2: r = first ? ~lvl : (b ? lvl : ~lvl);
			3'h3: r = first ? ~lvl : (b ? ~lvl : lvl);
			3'h4: r = first ? b : ~b;
			default: r = b;
		endcase
		return r;
	endfunction

	// Line decoder: bit recovered from the two halves of a cell
	function automatic logic dec(input logic [2:0] code, input logic prev, input logic h1,
		input logic h2);
		logic r;
		r = h1;
		unique case (code)
			3'h1: r = (h1 == prev);
			3'h2: r = (h1 == h2);
			3'h3: r = (h1 != h2);
			3'h4: r = h1;
			default: r = h1;
		endcase
		return r;
	endfunction

	logic [2:0] code;
	logic [2:0] cmode;
	logic [1:0] soc;
	logic div;
	logic wr;
	logic rd;
	logic clk_rise;
	logic clk_fall;
	logic cts_ok;
	logic rx_in;
	logic framed;
	logic bus_cm;
	logic rx_b;
	logic rx_second;

	assign code = q.cfg0[`SLCM_CFG0_CODE_LSB +: 3];
	assign cmode = q.cfg1[`SLCM_CFG1_CM_LSB +: 3];
	assign soc = q.cfg2[`SLCM_CFG2_SOC_LSB +: 2];
	assign div = q.cfg2[`SLCM_CFG2_DIV];
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	// Rising line clock edge starts a half cell on transmit; falling samples receive,
	// so the transmitted level leads the sample point by a quarter bit
	assign clk_rise = q.clk_s[1] && !q.clk_d;
	assign clk_fall = !q.clk_s[1] && q.clk_d;
	assign cts_ok = !q.cts_s[1];
	// Test loop feeds the encoded output straight back into the decoder
	assign rx_in = q.mode[`SLCM_MODE_TLP] ? q.txd_lvl : q.rxd_s[1];
	assign framed = !q.txc[`SLCM_TXC_ASYNC];
	assign bus_cm = q.cfg0[`SLCM_CFG0_BUS] && (cmode == 3'h0 || cmode == 3'h1);
	assign rx_b = dec(code, q.rx_prev, q.rx_last, rx_in) ^ div;
	// In test loop the cell phase is taken from the transmitter, so both halves pair up
	assign rx_second = q.mode[`SLCM_MODE_TLP] ? !q.bitcnt[0] : q.rxcnt[0];

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_take = 1'b0;
		next_q.cts_s = {q.cts_s[0], cts_n};
		next_q.cd_s = {q.cd_s[0], cd};
		next_q.rxd_s = {q.rxd_s[0], rxd};
		next_q.clk_s = {q.clk_s[0], line_clk};
		next_q.clk_d = q.clk_s[1];
		next_q.cts_d = q.cts_s[1];
		next_q.pready = psel && !penable;
		next_q.pslverr = 1'b0;
		next_q.rx_valid = 1'b0;
		// Any CTS edge is sticky; set beats a same-cycle software clear
		if (wr && paddr == `SLCM_OFF_ISR) begin
			next_q.isr = q.isr & ~pwdata[7:0];
		end
		if (q.cts_s[1] != q.cts_d) begin
			next_q.isr[`SLCM_ISR_CTSC] = 1'b1;
		end
		// Register writes
		if (wr) begin
			unique case (paddr)
				`SLCM_OFF_CFG0: next_q.cfg0 = pwdata[7:0];
				`SLCM_OFF_CFG1: next_q.cfg1 = pwdata[7:0];
				`SLCM_OFF_CFG2: next_q.cfg2 = pwdata[7:0];
				`SLCM_OFF_CFG3: next_q.cfg3 = pwdata[7:0];
				`SLCM_OFF_MODE: next_q.mode = pwdata[7:0];
				`SLCM_OFF_XBC: next_q.xbc = pwdata[7:0];
				`SLCM_OFF_IMR: next_q.imr = pwdata[7:0];
				`SLCM_OFF_TXC: next_q.txc = pwdata[2:0];
				default: next_q.txc = q.txc;
			endcase
		end
		// Register reads, answered with no wait state
		if (rd) begin
			unique case (paddr)
				`SLCM_OFF_CFG0: next_q.prdata = {24'h0, q.cfg0};
				`SLCM_OFF_CFG1: next_q.prdata = {24'h0, q.cfg1};
				`SLCM_OFF_CFG2: next_q.prdata = {24'h0, q.cfg2};
				`SLCM_OFF_CFG3: next_q.prdata = {24'h0, q.cfg3};
				`SLCM_OFF_MODE: next_q.prdata = {24'h0, q.mode};
				`SLCM_OFF_XBC: next_q.prdata = {24'h0, q.xbc};
				`SLCM_OFF_ISR: next_q.prdata = {24'h0, q.isr};
				`SLCM_OFF_IMR: next_q.prdata = {24'h0, q.imr};
				`SLCM_OFF_TXC: next_q.prdata = {29'h0, q.txc};
				`SLCM_OFF_STAT: next_q.prdata = {26'h0, q.tx, q.rx_en, q.rx_frame,
					q.cd_s[1], q.cts_s[1]};
				default: next_q.prdata = 32'h0;
			endcase
		end
		if (psel && !penable && paddr[1:0] != 2'h0) begin
			next_q.prdata = 32'h0;
		end
		// Error is decided at setup so that it stands together with pready
		if (psel && !penable && (paddr > `SLCM_OFF_STAT || paddr[1:0] != 2'h0)) begin
			next_q.pslverr = 1'b1;
		end
		// Transmit handshake
		unique case (q.tx)
			slcm_pkg::SLCM_IDLE: begin
				next_q.txd_lvl = q.txd_lvl;
				if (q.txc[`SLCM_TXC_SEND] && q.cfg0[`SLCM_CFG0_PU]) begin
					next_q.tx = slcm_pkg::SLCM_REQ;
				end
			end
			slcm_pkg::SLCM_REQ: begin
				if (!q.txc[`SLCM_TXC_SEND]) begin
					next_q.tx = slcm_pkg::SLCM_IDLE;
				end else if (cts_ok && clk_rise) begin
					next_q.tx = slcm_pkg::SLCM_SEND;
					next_q.bitcnt = 3'h0;
				end
			end
			slcm_pkg::SLCM_SEND: begin
				if (clk_rise) begin
					if (q.bitcnt[0] == 1'b0) begin
						next_q.tx_bit = tx_data ^ div;
						next_q.txd_lvl = enc(code, q.txd_lvl, tx_data ^ div, 1'b1);
						next_take = 1'b1;
					end else begin
						next_q.txd_lvl = enc(code, q.txd_lvl, q.tx_bit, 1'b0);
					end
					next_q.bitcnt = q.bitcnt + 3'h1;
				end
				if (!q.txc[`SLCM_TXC_SEND]) begin
					next_q.tx = slcm_pkg::SLCM_IDLE;
				end else if (!cts_ok && !framed) begin
					next_q.tx = slcm_pkg::SLCM_DRAIN;
				end else if (!cts_ok && q.txc[`SLCM_TXC_POOL]) begin
					next_q.tx = slcm_pkg::SLCM_IDLE;
					next_q.txc = 3'h0;
					next_q.isr[`SLCM_ISR_XMR] = 1'b1;
				end else if (!cts_ok) begin
					next_q.tx = slcm_pkg::SLCM_REQ;
					next_q.txd_lvl = 1'b1;
				end
			end
			slcm_pkg::SLCM_DRAIN: begin
				// Finish the character under way, then idle until CTS returns
				if (clk_rise) begin
					next_q.bitcnt = q.bitcnt + 3'h1;
					if (q.bitcnt == 3'h7) begin
						next_q.tx = slcm_pkg::SLCM_REQ;
						next_q.txd_lvl = 1'b1;
					end
				end
			end
		endcase
		// Receiver: carrier auto start outside clock mode one
		if (q.mode[`SLCM_MODE_RAC]) begin
			next_q.rx_en = 1'b1;
		end else if (q.xbc[`SLCM_XBC_CAS] && cmode != 3'h1) begin
			if (q.cd_s[1]) begin
				next_q.rx_en = 1'b1;
			end else if (q.rxcnt == 3'h0) begin
				next_q.rx_en = 1'b0;
			end
		end else begin
			next_q.rx_en = 1'b0;
		end
		if (q.rx_en && clk_fall) begin
			next_q.rxcnt = q.rxcnt + 3'h1;
			if (!rx_second) begin
				next_q.rx_last = rx_in;
			end else begin
				next_q.rx_bit = rx_b;
				next_q.rx_valid = 1'b1;
				next_q.rx_prev = (code == 3'h1) ? q.rx_last : rx_in;
				next_q.rx_frame = !rx_b || q.rx_frame;
			end
		end
		if (!q.rx_en) begin
			next_q.rx_frame = 1'b0;
			next_q.rxcnt = 3'h0;
		end
		// RTS pin function
		if (bus_cm && soc == 2'h2) begin
			next_q.rts_n = 1'b1;
		end else if (bus_cm && soc == 2'h3) begin
			next_q.rts_n = !q.rx_frame;
		end else if (q.mode[`SLCM_MODE_RTS]) begin
			next_q.rts_n = !q.txc[`SLCM_TXC_POOL];
		end else begin
			next_q.rts_n = (q.tx == slcm_pkg::SLCM_IDLE);
		end
		// Open drain unless push-pull selected
		next_q.txd = q.txd_lvl;
		next_q.txd_oe = q.cfg1[4] || !q.txd_lvl;
	end

	// ---------------------------------------------------------------
	// State register; control fields reset to zero, except imr which resets to all ones
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.imr <= `SLCM_IMR_RST;
			q.rts_n <= 1'b1;
			q.txd <= 1'b1;
			q.txd_lvl <= 1'b1;
			take_q <= 1'b0;
		end else begin
			q <= next_q;
			take_q <= next_take;
		end
	end

	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign tx_take = take_q;
	assign rx_data = q.rx_bit;
	assign rx_valid = q.rx_valid;
	assign tx_repeat = q.isr[`SLCM_ISR_XMR];
	assign cts_irq = q.isr[`SLCM_ISR_CTSC] && !q.imr[`SLCM_ISR_CTSC];
	assign rts_n = q.rts_n;
	assign txd = q.txd;
	assign txd_oe = q.txd_oe;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence cts_edge_s;
		q.cts_s[1] != q.cts_d;
	endsequence

	cts_flag_a: assert property (cts_edge_s |=> q.isr[`SLCM_ISR_CTSC])
		else $error("CTS change not flagged");
	rts_hold_a: assert property (bus_cm && soc == 2'h2 |=> rts_n)
		else $error("RTS not held high");
	rts_rx_a: assert property (bus_cm && soc == 2'h3 && q.rx_frame |=> !rts_n)
		else $error("RTS not low during reception");
	send_cts_a: assert property (q.tx == slcm_pkg::SLCM_REQ && !cts_ok
		|=> q.tx != slcm_pkg::SLCM_SEND)
		else $error("Sent without CTS");
	abort_a: assert property (q.tx == slcm_pkg::SLCM_SEND && !cts_ok && framed &&
		q.txc == 3'h1 |=> q.tx == slcm_pkg::SLCM_REQ && q.txd_lvl)
		else $error("Frame not aborted");
	xmr_a: assert property (q.tx == slcm_pkg::SLCM_SEND && !cts_ok && framed &&
		q.txc[`SLCM_TXC_POOL] && q.txc[`SLCM_TXC_SEND] |=> tx_repeat && q.txc == 3'h0)
		else $error("Transmitter not reset");
	async_a: assert property (q.tx == slcm_pkg::SLCM_SEND && !cts_ok && !framed &&
		q.txc[`SLCM_TXC_SEND] |=> q.tx == slcm_pkg::SLCM_DRAIN)
		else $error("Character not finished");
	cas_a: assert property (q.xbc[`SLCM_XBC_CAS] && cmode != 3'h1 && !q.mode[`SLCM_MODE_RAC]
		&& q.cd_s[1] |=> q.rx_en)
		else $error("Receiver not started by carrier");
	cd_low_a: assert property (q.rx_en && q.rxcnt != 3'h0 && !q.mode[`SLCM_MODE_RAC]
		&& q.xbc[`SLCM_XBC_CAS] && cmode != 3'h1 |=> q.rx_en)
		else $error("Byte cut short");
	loop_a: assert property (q.mode[`SLCM_MODE_TLP] |-> rx_in == q.txd_lvl)
		else $error("Loopback not connected");
	nrz_a: assert property (q.tx == slcm_pkg::SLCM_SEND && clk_rise && code == 3'h0 &&
		!q.bitcnt[0] && cts_ok && q.txc[`SLCM_TXC_SEND]
		|=> q.txd_lvl == $past(tx_data ^ div))
		else $error("NRZ level wrong");
endmodule

// ===== slcm_top_test.sv
// Self-checking bench of the line coder and modem handshake
`timescale 1ns/1ns
module slcm_top_test;
	logic pclk, presetn, psel, penable, pwrite, tx_data, run, grant, carrier;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, line_clk, cts_n, cd, rxd, tx_take, rx_data, rx_valid;
	logic tx_repeat, cts_irq, rts_n, txd, txd_oe, rerr;
	int n_errors = 0;
	int total_checks = 0;
	int k;

	slcm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .line_clk(line_clk), .cts_n(cts_n), .cd(cd), .rxd(rxd),
		.tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_repeat(tx_repeat), .cts_irq(cts_irq), .rts_n(rts_n), .txd(txd), .txd_oe(txd_oe));
	slcm_modem modem (.run(run), .grant(grant), .carrier(carrier), .line_clk(line_clk),
		.cts_n(cts_n), .cd(cd), .rxd(rxd));

	// ----------------
	// Shared tasks
	// ----------------
	task chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// One APB transfer; request held until pready is seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
		chk(pready === 1'b1, "no ready");
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk((rdat & mask) === e, "read value");
	endtask
	// Bounded wait, since a hung coder must not stall the run
	task automatic wait_for(ref logic s, input logic v, input string m);
		int i;
		for (i = 0; i < 400 && s !== v; i++) @(posedge pclk);
		chk(s === v, m);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------
	// Scenarios
	// ----------------
	task t_reset;
		for (k = 0; k < 5; k++) rd(12'(k * 4), 32'hffffffff, 32'h00000000);
		rd(12'h01c, 32'hffffffff, 32'h000000ff);
		chk(rts_n === 1'b1 && txd_oe === 1'b0, "reset outputs");
		apb(1'b0, 12'h028, 32'h00000000);
		chk(rerr === 1'b1, "unmapped accepted");
		$display("reset test done");
	endtask
	task t_tx;
		apb(1'b1, 12'h000, 32'h00000080);
		apb(1'b1, 12'h020, 32'h00000001);
		repeat (3) @(posedge pclk);
		chk(rts_n === 1'b0, "no request");
		k = 0;
		repeat (100) @(posedge pclk) if (tx_take === 1'b1) k++;
		chk(k == 0, "sent without grant");
		grant <= 1'b1;
		wait_for(tx_take, 1'b1, "no take");
		wait_for(txd, 1'b0, "nrz level");
		grant <= 1'b0;
		repeat (30) @(posedge pclk);
		chk(txd === 1'b1, "no abort idle");
		grant <= 1'b1;
		wait_for(txd, 1'b0, "no resend");
		apb(1'b1, 12'h008, 32'h00000008);
		tx_data <= 1'b1;
		repeat (40) @(posedge pclk);
		chk(txd === 1'b0, "inversion");
		apb(1'b1, 12'h020, 32'h00000005);
		grant <= 1'b0;
		wait_for(tx_repeat, 1'b1, "no repeat");
		repeat (2) @(posedge pclk);
		chk(rts_n === 1'b1, "rts kept");
		rd(12'h020, 32'h000000ff, 32'h00000000);
		rd(12'h018, 32'h00000012, 32'h00000012);
		chk(cts_irq === 1'b0, "masked irq");
		apb(1'b1, 12'h01c, 32'h000000fd);
		repeat (2) @(posedge pclk);
		chk(cts_irq === 1'b1, "irq off");
		apb(1'b1, 12'h018, 32'h00000012);
		repeat (2) @(posedge pclk);
		chk(cts_irq === 1'b0 && tx_repeat === 1'b0, "clear");
		apb(1'b1, 12'h000, 32'h00000090);
		apb(1'b1, 12'h008, 32'h00000080);
		grant <= 1'b1;
		apb(1'b1, 12'h020, 32'h00000001);
		repeat (5) @(posedge pclk);
		chk(rts_n === 1'b1, "rts not held");
		apb(1'b1, 12'h008, 32'h00000000);
		$display("transmit test done");
	endtask
	// Every coding looped back with both bit values
	task t_codes;
		apb(1'b1, 12'h010, 32'h00000009);
		for (int c = 0; c < 5; c++) begin
			for (int b = 0; b < 2; b++) begin
				apb(1'b1, 12'h000, {24'h000000, 1'b1, 2'b00, 3'(c), 2'b00});
				tx_data <= 1'(b);
				repeat (4) begin
					@(posedge pclk);
					wait_for(rx_valid, 1'b1, "no bit");
				end
				chk(rx_data === 1'(b), "decoded bit");
			end
		end
		apb(1'b1, 12'h010, 32'h00000000);
		$display("coding test done");
	endtask
	task t_carrier;
		apb(1'b1, 12'h020, 32'h00000000);
		rd(12'h024, 32'h00000008, 32'h00000000);
		apb(1'b1, 12'h014, 32'h00000080);
		carrier <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(12'h024, 32'h0000000a, 32'h0000000a);
		$display("carrier test done");
	endtask

	// ----------------
	// Clock, reset and sequence
	// ----------------
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#400000;
		n_errors++;
		print_verdict();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		tx_data = 1'b0;
		run = 1'b0;
		grant = 1'b0;
		carrier = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		run <= 1'b1;
		t_tx();
		t_codes();
		t_carrier();
		print_verdict();
	end
endmodule
